// File: dv/gpm_pad_model.sv
// Pad and peripheral side model: new random pin levels every cycle.
// Assumes the bench seeds $urandom before the first clock edge.
`timescale 1ns/1ps
module gpm_pad_model (
  input wire logic clk_i,
  output logic [95:0] out_value_o,
  output logic [95:0] af_out_o,
  output logic [95:0] af_oe_o,
  output logic [95:0] pad_in_o
);
  // Levels change just after the edge, so every mode meets both values and enables.
  initial begin
    {out_value_o, af_out_o, af_oe_o, pad_in_o} = '0;
  end
  always @(posedge clk_i) begin
    #1;
    {out_value_o, af_out_o, af_oe_o, pad_in_o} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
      $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
  end
endmodule : gpm_pad_model

// File: dv/gpm_top_bench.sv
// Self-checking bench: bus reads and writes, scoreboard on registers and pads.
// Assumes the pad model drives all peripheral and pad inputs.
`timescale 1ns/1ps
`include "gpm_params.svh"
module gpm_top_bench;
  import gpm_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sel = 1'b0;
  logic wr = 1'b0;
  gpm_word_t addr = '0;
  gpm_word_t wdata = '0;
  gpm_word_t rdata;
  logic [95:0] ov, af, ao, pin, drv, pdo, poe, pie, pull, ist;
  logic [191:0] mode;
  logic [191:0] mode_m = {128'h0, `GPM_MODE_RST_PORT_B, 32'h0};
  logic [95:0] drv_m = '0;
  gpm_word_t exp_q[$];
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  gpm_top gpm_top_inst (.CLK_I(clk), .NRST_I(nrst), .BUS_SEL_I(sel), .BUS_WR_I(wr), .BUS_ADDR_I(addr),
    .BUS_WDATA_I(wdata), .BUS_RDATA_O(rdata), .OUT_VALUE_I(ov), .AF_OUT_I(af), .AF_OE_I(ao), .PAD_IN_I(pin),
    .PIN_MODE_O(mode), .PIN_DRV_O(drv), .PAD_DO_O(pdo), .PAD_OE_O(poe), .PAD_IE_O(pie),
    .PAD_PULL_EN_O(pull), .PIN_IN_STATE_O(ist));
  gpm_pad_model gpm_pad_model_inst (.clk_i(clk), .out_value_o(ov), .af_out_o(af), .af_oe_o(ao), .pad_in_o(pin));

  task close_out;
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  task chk(input string nm, input logic [191:0] e, input logic [191:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One access per call; the model follows writes and each read queues its word.
  // port and offset decode.
  task acc(input logic w, input logic [2:0] p, input logic [9:0] o, input gpm_word_t d);
    logic ok;
    ok = p < 3'h6 && (o == `GPM_OFF_MODE || o == `GPM_OFF_DRV);
    @(posedge clk);
    #1;
    {sel, wr, addr, wdata} = {1'b1, w, `GPM_PORT0_BASE + {19'h0, p, o}, d};
    if (w && ok && o == `GPM_OFF_MODE) mode_m[p*32+:32] = d;
    if (w && ok && o == `GPM_OFF_DRV) drv_m[p*16+:16] = d[15:0];
    if (!w) exp_q.push_back(!ok ? 32'h0 : o == `GPM_OFF_MODE ? mode_m[p*32+:32] : {16'h0, drv_m[p*16+:16]});
  endtask : acc

  // Main sequence: reset, reset values, then random back-to-back traffic with stray addresses.
  initial begin
    logic [2:0] p;
    logic [9:0] o;
    gpm_word_t d;
    logic [9:0] offs [5] = '{10'h000, 10'h004, 10'h008, 10'h002, 10'h3fc};
    void'($urandom(32'hfb08));
    repeat (20) @(posedge clk);
    #1;
    nrst = 1'b1;
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, 3'(i), `GPM_OFF_MODE, 32'h0);
      acc(1'b0, 3'(i), `GPM_OFF_DRV, 32'h0);
    end
    for (int i = 0; i < 700; i++) begin
      p = 3'($urandom % 8);
      o = offs[$urandom % 5];
      d = $urandom;
      if (o == `GPM_OFF_DRV) d[31:16] = 16'h0;
      acc(1'b1, p, o, d);
      acc(1'b0, p, o, 32'h0);
    end
    @(posedge clk);
    #1;
    sel = 1'b0;
    repeat (3) @(posedge clk);
    close_out();
  end

  // Scoreboard: snapshot model and pad inputs at the edge, check settled outputs after it.
  always @(posedge clk) begin
    logic rd;
    logic [191:0] em;
    logic [95:0] ed, v, f, e, n;
    logic [1:0] m;
    logic en, s, oe;
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      close_out();
    end
    if (nrst) begin
      {rd, em, ed, v, f, e, n} = {sel && !wr, mode_m, drv_m, ov, af, ao, pin};
      #1;
      if (rd) chk("read_data", {160'h0, exp_q.pop_front()}, {160'h0, rdata});
      chk("pin_mode", em, mode);
      chk("pin_drv", {96'h0, ed}, {96'h0, drv});
      for (int i = 0; i < 96; i++) begin
        m = em[2*i+:2];
        s = m == 2'h1 ? v[i] : f[i];
        en = m == 2'h1 || (m == 2'h2 && e[i]);
        oe = en && !(ed[i] && s);
        chk("pad_oe", 192'(oe), 192'(poe[i]));
        chk("pad_do", 192'(en && !ed[i] && s), 192'(pdo[i]));
        chk("pad_ie", 192'(m != 2'h3), 192'(pie[i]));
        chk("pull_en", 192'(m != 2'h3), 192'(pull[i]));
        chk("in_state", 192'(m != 2'h3 && n[i]), 192'(ist[i]));
      end
    end
  end
endmodule : gpm_top_bench

// File: logic/gpm_params.svh
// Constants for the pin mode and driver type configuration block.
// Assumes byte addressing on the system bus and 32-bit register words.
`ifndef GPM_PARAMS_SVH
`define GPM_PARAMS_SVH

// Port placement on the system bus.
`define GPM_PORT0_BASE 32'h4800_0000
`define GPM_PORT_STRIDE 32'h0000_0400
`define GPM_PORT_COUNT 6
`define GPM_PORT_B_INDEX 1
`define GPM_PINS 16

// Register offsets within one port and their decode width.
`define GPM_OFF_W 10
`define GPM_OFF_MODE 10'h000
`define GPM_OFF_DRV 10'h004

// Reset values.
`define GPM_MODE_RST_PORT_B 32'h000a_8280
`define GPM_MODE_RST_OTHER 32'h0000_0000
`define GPM_DRV_RST 16'h0000

`endif

// File: logic/gpm_pkg.sv
// Types shared by the pin mode and driver type configuration block.
// Assumes gpm_params.svh supplies all numeric constants.
package gpm_pkg;

  // Two-bit per-pin operating mode, in field code order.
  typedef enum logic [1:0] {
    GPM_MODE_INPUT,
    GPM_MODE_OUTPUT,
    GPM_MODE_ALTFN,
    GPM_MODE_ANALOG
  } gpm_pin_mode_t;

  // One-bit per-pin output driver type.
  typedef enum logic {
    GPM_DRV_PUSH_PULL,
    GPM_DRV_OPEN_DRAIN
  } gpm_drv_t;

  typedef logic [31:0] gpm_word_t;

endpackage : gpm_pkg

// File: logic/gpm_port.sv
// One port: pin mode and driver type registers plus per-pin pad control.
// Assumes the parent decodes the bus and presents one-cycle write strobes.
`timescale 1ns/1ps
`include "gpm_params.svh"

module gpm_port #(
  parameter logic [31:0] MODE_RST = `GPM_MODE_RST_OTHER
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic mode_we_i,
  input wire logic drv_we_i,
  input wire gpm_pkg::gpm_word_t wdata_i,
  input wire logic [15:0] out_value_i,
  input wire logic [15:0] af_out_i,
  input wire logic [15:0] af_oe_i,
  input wire logic [15:0] pad_in_i,
  output logic [31:0] mode_o,
  output logic [15:0] drv_o,
  output logic [15:0] pad_do_o,
  output logic [15:0] pad_oe_o,
  output logic [15:0] pad_ie_o,
  output logic [15:0] pull_en_o,
  output logic [15:0] in_state_o
);
  import gpm_pkg::*;

  // Every check in this port runs on the one bus clock and is quiet while reset is held.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  logic [31:0] mode_r;
  logic [31:0] mode_nxt;
  logic [15:0] drv_r;
  logic [15:0] drv_nxt;
  logic [15:0] do_nxt;
  logic [15:0] oe_nxt;
  logic [15:0] ie_nxt;
  logic [15:0] pull_nxt;
  logic [15:0] in_nxt;

  assign mode_nxt = mode_we_i ? wdata_i : mode_r;
  assign drv_nxt = drv_we_i ? wdata_i[15:0] : drv_r;

  // Pad control is computed from the next configuration so a write reaches the pins on the same edge as the register.
  for (genvar i = 0; i < `GPM_PINS; i++) begin : g_pin
    gpm_pin_mode_t md;
    logic src;
    logic want;
    assign md = gpm_pin_mode_t'(mode_nxt[2*i +: 2]);
    assign src = (md == GPM_MODE_ALTFN) ? af_out_i[i] : out_value_i[i];
    assign want = (md == GPM_MODE_OUTPUT) || ((md == GPM_MODE_ALTFN) && af_oe_i[i]);
    assign oe_nxt[i] = want && (drv_nxt[i] == GPM_DRV_PUSH_PULL || !src);
    assign do_nxt[i] = want && (drv_nxt[i] == GPM_DRV_PUSH_PULL) && src;
    assign ie_nxt[i] = (md != GPM_MODE_ANALOG);
    assign pull_nxt[i] = (md != GPM_MODE_ANALOG);
    assign in_nxt[i] = (md != GPM_MODE_ANALOG) && pad_in_i[i];

    a_od_never_high: assert property ((pad_oe_o[i] && drv_r[i]) |-> !pad_do_o[i])
      else $error("open-drain pin driven high");
    a_analog_quiet: assert property ((mode_r[2*i +: 2] == 2'h3) |->
      (!pad_oe_o[i] && !pad_ie_o[i] && !pull_en_o[i] && !in_state_o[i]))
      else $error("analog pin not quiet");
    a_input_undriven: assert property ((mode_r[2*i +: 2] == 2'h0) |-> !pad_oe_o[i])
      else $error("input pin driven");
    a_push_follows: assert property ((mode_r[2*i +: 2] == 2'h1 && !drv_r[i]) |->
      (pad_oe_o[i] && pad_do_o[i] == $past(out_value_i[i])))
      else $error("push-pull output does not follow value");
  end

  // Configuration and pad control flops.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_r <= MODE_RST;
      drv_r <= `GPM_DRV_RST;
      pad_do_o <= 16'h0000;
      pad_oe_o <= 16'h0000;
      pad_ie_o <= 16'h0000;
      pull_en_o <= 16'h0000;
      in_state_o <= 16'h0000;
    end else begin
      mode_r <= mode_nxt;
      drv_r <= drv_nxt;
      pad_do_o <= do_nxt;
      pad_oe_o <= oe_nxt;
      pad_ie_o <= ie_nxt;
      pull_en_o <= pull_nxt;
      in_state_o <= in_nxt;
    end
  end

  assign mode_o = mode_r;
  assign drv_o = drv_r;

  sequence s_mode_write;
    mode_we_i;
  endsequence

  a_mode_write_lands: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_mode_write |=> (mode_r == $past(wdata_i)))
    else $error("mode write not applied next cycle");
  a_drv_write_lands: assert property (@(posedge clk_i) disable iff (!nrst_i)
    drv_we_i |=> (drv_r == $past(wdata_i[15:0])))
    else $error("driver write not applied next cycle");
  a_mode_holds: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !mode_we_i |=> $stable(mode_r))
    else $error("mode changed without write");

endmodule : gpm_port

// File: logic/gpm_top.sv
// Top of the pin mode and driver type block: bus decode, read mux and six ports.
// Assumes a simple word bus: select, write flag, byte address, write data, registered read data.
`timescale 1ns/1ps
`include "gpm_params.svh"

// Behaviour
// - six ports, 0x400 apart from first base.
// - mode register holds two bits per pin.
// - second port resets to nonzero mode default.
// - modes: input, output, alternate, analog.
// - driver register holds one bit per pin.
// - driver bit 0 push-pull, 1 open-drain.
// - fields writable, readable, held until rewritten.
// - open-drain floats on one, push-pull drives.
// - analog pins: no input, drive, pulls.
module gpm_top #(
  parameter int PORT_COUNT = `GPM_PORT_COUNT
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic BUS_SEL_I,
  input wire logic BUS_WR_I,
  input wire gpm_pkg::gpm_word_t BUS_ADDR_I,
  input wire gpm_pkg::gpm_word_t BUS_WDATA_I,
  output gpm_pkg::gpm_word_t BUS_RDATA_O,
  input wire logic [PORT_COUNT*16-1:0] OUT_VALUE_I,
  input wire logic [PORT_COUNT*16-1:0] AF_OUT_I,
  input wire logic [PORT_COUNT*16-1:0] AF_OE_I,
  input wire logic [PORT_COUNT*16-1:0] PAD_IN_I,
  output logic [PORT_COUNT*32-1:0] PIN_MODE_O,
  output logic [PORT_COUNT*16-1:0] PIN_DRV_O,
  output logic [PORT_COUNT*16-1:0] PAD_DO_O,
  output logic [PORT_COUNT*16-1:0] PAD_OE_O,
  output logic [PORT_COUNT*16-1:0] PAD_IE_O,
  output logic [PORT_COUNT*16-1:0] PAD_PULL_EN_O,
  output logic [PORT_COUNT*16-1:0] PIN_IN_STATE_O
);
  import gpm_pkg::*;

  logic [31:0] rel_addr;
  logic [2:0] port_idx;
  logic [`GPM_OFF_W-1:0] reg_off;
  logic in_range;
  logic map_hit;
  logic hit_mode;
  logic hit_drv;
  logic rd_en;
  logic [31:0] mode_w [PORT_COUNT];
  logic [15:0] drv_w [PORT_COUNT];
  gpm_word_t rdata_r;
  gpm_word_t rdata_nxt;

  assign rel_addr = BUS_ADDR_I - `GPM_PORT0_BASE;
  assign in_range = (rel_addr < (`GPM_PORT_STRIDE * 32'(PORT_COUNT)));
  // The stride is a power of two, so the port index is a plain bit slice.
  assign port_idx = rel_addr[12:10];
  assign reg_off = rel_addr[`GPM_OFF_W-1:0];
  assign map_hit = BUS_SEL_I && in_range && (BUS_ADDR_I[1:0] == 2'h0);
  assign hit_mode = map_hit && (reg_off == `GPM_OFF_MODE);
  assign hit_drv = map_hit && (reg_off == `GPM_OFF_DRV);
  assign rd_en = BUS_SEL_I && !BUS_WR_I;

  // Read data; unmapped or misaligned reads answer zero rather than aliasing a register.
  // driver upper bits zero
  assign rdata_nxt = hit_mode ? mode_w[port_idx] :
                     hit_drv ? {16'h0000, drv_w[port_idx]} : 32'h0000_0000;

  // Read data register holds the last read answer.
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign BUS_RDATA_O = rdata_r;

  // One register set per port; only the second port has a nonzero mode default.
  for (genvar g = 0; g < PORT_COUNT; g++) begin : g_port
    localparam logic [31:0] MRST = (g == `GPM_PORT_B_INDEX) ? `GPM_MODE_RST_PORT_B : `GPM_MODE_RST_OTHER;
    logic sel_me;
    logic [15:0] drv_loc;
    assign sel_me = BUS_WR_I && (port_idx == 3'(g));

    gpm_port #(
      .MODE_RST(MRST)
    ) u_port (
      .clk_i(CLK_I),
      .nrst_i(NRST_I),
      .mode_we_i(hit_mode && sel_me),
      .drv_we_i(hit_drv && sel_me),
      .wdata_i(BUS_WDATA_I),
      .out_value_i(OUT_VALUE_I[g*16 +: 16]),
      .af_out_i(AF_OUT_I[g*16 +: 16]),
      .af_oe_i(AF_OE_I[g*16 +: 16]),
      .pad_in_i(PAD_IN_I[g*16 +: 16]),
      .mode_o(PIN_MODE_O[g*32 +: 32]),
      .drv_o(drv_loc),
      .pad_do_o(PAD_DO_O[g*16 +: 16]),
      .pad_oe_o(PAD_OE_O[g*16 +: 16]),
      .pad_ie_o(PAD_IE_O[g*16 +: 16]),
      .pull_en_o(PAD_PULL_EN_O[g*16 +: 16]),
      .in_state_o(PIN_IN_STATE_O[g*16 +: 16])
    );

    assign PIN_DRV_O[g*16 +: 16] = drv_loc;
    assign mode_w[g] = PIN_MODE_O[g*32 +: 32];
    assign drv_w[g] = drv_loc;
  end

  // Checks on decode, read answers and reset defaults.
  a_read_mode: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (rd_en && hit_mode) |=> (BUS_RDATA_O == $past(rdata_nxt)) && (BUS_RDATA_O == mode_w[$past(port_idx)]))
    else $error("mode read returns wrong value");
  a_drv_upper_zero: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (rd_en && hit_drv) |=> (BUS_RDATA_O[31:16] == 16'h0000))
    else $error("driver read upper bits not zero");
  a_unmapped_zero: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (rd_en && !map_hit) |=> (BUS_RDATA_O == 32'h0000_0000))
    else $error("unmapped read not zero");
  a_port_b_write: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (BUS_SEL_I && BUS_WR_I && BUS_ADDR_I == (`GPM_PORT0_BASE + `GPM_PORT_STRIDE)) |=>
    (PIN_MODE_O[63:32] == $past(BUS_WDATA_I)))
    else $error("second port base write missed");
  a_reset_values: assert property (@(posedge CLK_I)
    $rose(NRST_I) |-> (PIN_MODE_O[63:32] == `GPM_MODE_RST_PORT_B) && (PIN_MODE_O[31:0] == 32'h0) &&
    (PIN_MODE_O[191:64] == 128'h0) && (PIN_DRV_O == 96'h0))
    else $error("wrong reset defaults");

endmodule : gpm_top
